// ---- core_state_addr.sv ----
`timescale 1ns/100ps
`include "core_map.svh"

module core_state_addr
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Core rate select: divide by least divide shifted left by this
  input  wire logic [1:0]  clk_sel_i,
  output logic             core_ce_o,
  output logic             halted_o,
  // Program memory bus
  output logic [15:0]      prog_addr_o,
  output logic             prog_rd_o,
  input  wire logic [7:0]  prog_data_i,
  // Data RAM bus
  output logic [7:0]       ram_addr_o,
  output logic             ram_rd_o,
  output logic             ram_wr_o,
  output logic [7:0]       ram_wdata_o,
  input  wire logic [7:0]  ram_rdata_i,
  // Register space bus
  output logic [7:0]       reg_addr_o,
  output logic             reg_bank_o,
  output logic             reg_rd_o,
  output logic             reg_wr_o,
  output logic [7:0]       reg_wdata_o,
  input  wire logic [7:0]  reg_rdata_i
);
  import core_pkg::*;

  localparam int DIV_W = 8;

  logic [DIV_W-1:0] div_cnt_reg, div_cnt_next, div_limit;
  logic             ce_reg, ce_next;
  logic [7:0]       acc_reg, acc_next, idx_reg, idx_next, sp_reg, sp_next;
  logic [7:0]       flags_reg, flags_next;
  logic [15:0]      pc_reg, pc_next;
  logic [7:0]       op_reg, op_next, op1_reg, op1_next, op2_reg, op2_next;
  logic [4:0]       cyc_reg, cyc_next, last_cyc;
  core_state_t      st_reg, st_next;
  op_info_t         info;
  logic [8:0]       page_sum, alu;
  logic             page_pen, is_jump, run_ce;
  logic             upd_z, upd_c, cval;
  logic [15:0]      jmp_target;
  logic [15:0]      prog_addr_next;
  logic             prog_rd_next, ram_rd_next, ram_wr_next;
  logic [7:0]       ram_addr_next, ram_wdata_next;
  logic             rq_rd, rq_wr, flags_hit;
  logic [7:0]       rq_addr, rq_wdata, rq_rdata;
  logic             rst_seen_reg;

  // Opcode table: class, core cycles, bytes
  function automatic op_info_t decode(input logic [7:0] op);
    op_info_t d;
    d = '{kind: K_NOP, cycles: 4'h4, len: 2'h1};
    case (op)
      `OP_ADD_A_IMM:  d = '{kind: K_ADD_A,      cycles: 4'h4, len: 2'h2};
      `OP_PUSH_A:     d = '{kind: K_PUSH_A,     cycles: 4'h4, len: 2'h1};
      `OP_PUSH_X:     d = '{kind: K_PUSH_X,     cycles: 4'h4, len: 2'h1};
      `OP_POP_A:      d = '{kind: K_POP_A,      cycles: 4'h5, len: 2'h1};
      `OP_POP_X:      d = '{kind: K_POP_X,      cycles: 4'h5, len: 2'h1};
      `OP_AND_A_IMM:  d = '{kind: K_AND_A,      cycles: 4'h4, len: 2'h2};
      `OP_HALT:       d = '{kind: K_HALT,       cycles: 4'h9, len: 2'h1};
      `OP_XOR_A_IMM:  d = '{kind: K_XOR_A,      cycles: 4'h4, len: 2'h2};
      `OP_NOP:        d = '{kind: K_NOP,        cycles: 4'h4, len: 2'h1};
      `OP_SWAP_A_X:   d = '{kind: K_SWAP_A_X,   cycles: 4'h5, len: 2'h1};
      `OP_SWAP_A_SP:  d = '{kind: K_SWAP_A_SP,  cycles: 4'h5, len: 2'h1};
      `OP_MOV_A_IMM:  d = '{kind: K_MOV_A_IMM,  cycles: 4'h4, len: 2'h2};
      `OP_MOV_X_IMM:  d = '{kind: K_MOV_X_IMM,  cycles: 4'h4, len: 2'h2};
      `OP_MOV_A_X:    d = '{kind: K_MOV_A_X,    cycles: 4'h4, len: 2'h1};
      `OP_MOV_X_A:    d = '{kind: K_MOV_X_A,    cycles: 4'h4, len: 2'h1};
      `OP_RD_REG:     d = '{kind: K_RD_REG,     cycles: 4'h6, len: 2'h2};
      `OP_WR_REG_A:   d = '{kind: K_WR_REG_A,   cycles: 4'h5, len: 2'h2};
      `OP_WR_REG_IMM: d = '{kind: K_WR_REG_IMM, cycles: 4'h8, len: 2'h3};
      `OP_AND_FL:     d = '{kind: K_AND_FL,     cycles: 4'h4, len: 2'h2};
      `OP_OR_FL:      d = '{kind: K_OR_FL,      cycles: 4'h4, len: 2'h2};
      `OP_XOR_FL:     d = '{kind: K_XOR_FL,     cycles: 4'h4, len: 2'h2};
      `OP_INC_A:      d = '{kind: K_INC_A,      cycles: 4'h4, len: 2'h1};
      `OP_INC_X:      d = '{kind: K_INC_X,      cycles: 4'h4, len: 2'h1};
      `OP_DEC_A:      d = '{kind: K_DEC_A,      cycles: 4'h4, len: 2'h1};
      `OP_DEC_X:      d = '{kind: K_DEC_X,      cycles: 4'h4, len: 2'h1};
      `OP_LJMP:       d = '{kind: K_LJMP,       cycles: 4'h7, len: 2'h3};
      default:
      begin
        if (op[7:4] == `OP_JMP_HI)
          d = '{kind: K_JMP, cycles: 4'h5, len: 2'h2};
      end
    endcase
    return d;
  endfunction : decode

  // Core rate divider; the least divide keeps the core at or below its top rate
  assign div_limit = DIV_W'(`CORE_MIN_DIV << clk_sel_i) - DIV_W'(1);
  always_comb
  begin
    div_cnt_next = div_cnt_reg + DIV_W'(1);
    ce_next      = 1'b0;
    if (div_cnt_reg >= div_limit)
    begin
      div_cnt_next = '0;
      ce_next      = 1'b1;
    end
  end

  // Decode and page-crossing penalty
  assign info       = decode(op_reg);
  assign is_jump    = (info.kind == K_JMP) || (info.kind == K_LJMP);
  assign page_sum   = {1'b0, pc_reg[7:0]} + {7'h00, info.len};
  assign page_pen   = !is_jump && page_sum[8];
  assign last_cyc   = {1'b0, info.cycles} - 5'h01 + {4'h0, page_pen};
  assign jmp_target = pc_reg + 16'h0001 + {{4{op_reg[3]}}, op_reg[3:0], op1_reg};
  assign run_ce     = ce_reg && (st_reg == ST_RUN);

  // Architectural state update, one step per core cycle
  always_comb
  begin
    acc_next = acc_reg;  idx_next = idx_reg;  sp_next = sp_reg;
    flags_next = flags_reg;  pc_next = pc_reg;  st_next = st_reg;
    op_next = op_reg;  op1_next = op1_reg;  op2_next = op2_reg;
    cyc_next = cyc_reg;
    alu = 9'h000;  upd_z = 1'b0;  upd_c = 1'b0;  cval = 1'b0;
    if (run_ce)
    begin
      cyc_next = cyc_reg + 5'h01;
      // Byte at pc+k stands on the bus at the edge ending core cycle k
      if (cyc_reg == 5'd0) op_next = prog_data_i;
      if (cyc_reg == 5'd1) op1_next = prog_data_i;
      if (cyc_reg == 5'(`CYC_LAST_FETCH)) op2_next = prog_data_i;
      if (cyc_reg == 5'(`CYC_EXEC))
      begin
        case (info.kind)
          K_MOV_A_IMM: begin acc_next = op1_reg; upd_z = 1'b1; end
          K_MOV_X_IMM: idx_next = op1_reg;
          K_MOV_A_X:   begin acc_next = idx_reg; upd_z = 1'b1; end
          K_MOV_X_A:   idx_next = acc_reg;
          K_SWAP_A_X:  begin acc_next = idx_reg; idx_next = acc_reg; upd_z = 1'b1; end
          K_SWAP_A_SP: begin acc_next = sp_reg; sp_next = acc_reg; upd_z = 1'b1; end
          K_AND_FL:    flags_next = flags_reg & op1_reg;
          K_OR_FL:     flags_next = flags_reg | op1_reg;
          K_XOR_FL:    flags_next = flags_reg ^ op1_reg;
          K_AND_A:     begin acc_next = acc_reg & op1_reg; upd_z = 1'b1; end
          K_XOR_A:     begin acc_next = acc_reg ^ op1_reg; upd_z = 1'b1; end
          K_ADD_A, K_INC_A, K_DEC_A:
          begin
            alu = (info.kind == K_ADD_A) ? {1'b0, acc_reg} + {1'b0, op1_reg} :
                  (info.kind == K_INC_A) ? {1'b0, acc_reg} + 9'h001 :
                                           {1'b0, acc_reg} - 9'h001;
            acc_next = alu[7:0];  upd_z = 1'b1;  upd_c = 1'b1;  cval = alu[8];
          end
          K_INC_X, K_DEC_X:
          begin
            alu = (info.kind == K_INC_X) ? {1'b0, idx_reg} + 9'h001 :
                                           {1'b0, idx_reg} - 9'h001;
            idx_next = alu[7:0];  upd_z = 1'b1;  upd_c = 1'b1;  cval = alu[8];
          end
          K_PUSH_A, K_PUSH_X: sp_next = sp_reg + 8'h01;
          K_POP_A, K_POP_X:   sp_next = sp_reg - 8'h01;
          default: ;
        endcase
      end
      if (cyc_reg == 5'(`CYC_LATE))
      begin
        // Pop and register reads land one core cycle after their request
        case (info.kind)
          K_POP_A:  begin acc_next = ram_rdata_i; upd_z = 1'b1; end
          K_POP_X:  idx_next = ram_rdata_i;
          K_RD_REG: begin acc_next = rq_rdata; upd_z = 1'b1; end
          default: ;
        endcase
      end
      if (upd_z) flags_next[`FLAG_Z_BIT] = (info.kind inside {K_INC_X, K_DEC_X}) ?
                                           (idx_next == 8'h00) : (acc_next == 8'h00);
      if (upd_c) flags_next[`FLAG_C_BIT] = cval;
      // Register write to the flag address lands in the flags
      if (rq_wr && flags_hit) flags_next = rq_wdata;
      if (cyc_reg == last_cyc)
      begin
        cyc_next = 5'h00;
        pc_next  = (info.kind == K_JMP)  ? jmp_target :
                   (info.kind == K_LJMP) ? {op1_reg, op2_reg} :
                   pc_reg + {14'h0000, info.len};
        if (info.kind == K_HALT) st_next = ST_HALT;
      end
    end
  end

  // Bus requests for the current core cycle
  always_comb
  begin
    prog_rd_next   = (st_reg == ST_RUN) && (cyc_reg <= 5'(`CYC_LAST_FETCH));
    prog_addr_next = pc_reg + {11'h000, cyc_reg};
    ram_rd_next    = 1'b0;
    ram_wr_next    = 1'b0;
    ram_addr_next  = sp_reg;
    ram_wdata_next = (info.kind == K_PUSH_X) ? idx_reg : acc_reg;
    rq_rd          = 1'b0;
    rq_wr          = 1'b0;
    rq_addr        = op1_reg;
    rq_wdata       = acc_reg;
    if (st_reg == ST_RUN && cyc_reg == 5'(`CYC_EXEC))
    begin
      ram_wr_next = (info.kind == K_PUSH_A) || (info.kind == K_PUSH_X);
      ram_rd_next = (info.kind == K_POP_A) || (info.kind == K_POP_X);
      if (ram_rd_next) ram_addr_next = sp_reg - 8'h01;
      rq_rd = (info.kind == K_RD_REG);
      rq_wr = (info.kind == K_WR_REG_A);
    end
    if (st_reg == ST_RUN && cyc_reg == 5'(`CYC_LATE) && info.kind == K_WR_REG_IMM)
    begin
      rq_wr    = 1'b1;
      rq_wdata = op2_reg;
    end
  end

  // Register space port, bank taken from the flags
  reg_space_port u_reg_port (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .req_rd_i    (rq_rd),
    .req_wr_i    (rq_wr),
    .req_addr_i  (rq_addr),
    .req_wdata_i (rq_wdata),
    .bank_i      (flags_reg[`FLAG_BANK_BIT]),
    .flags_i     (flags_reg),
    .flags_hit_o (flags_hit),
    .rd_data_o   (rq_rdata),
    .reg_addr_o  (reg_addr_o),
    .reg_bank_o  (reg_bank_o),
    .reg_rd_o    (reg_rd_o),
    .reg_wr_o    (reg_wr_o),
    .reg_wdata_o (reg_wdata_o),
    .reg_rdata_i (reg_rdata_i)
  );

  // State and registered bus outputs
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_cnt_reg <= '0;  ce_reg <= 1'b0;  rst_seen_reg <= 1'b1;
      acc_reg <= `ACC_RESET;  idx_reg <= `IDX_RESET;
      sp_reg <= `SP_RESET;  pc_reg <= `PC_RESET;  flags_reg <= `FLAGS_RESET;
      op_reg <= 8'h00;  op1_reg <= 8'h00;  op2_reg <= 8'h00;
      cyc_reg <= 5'h00;  st_reg <= ST_RUN;
      prog_addr_o <= 16'h0000;  prog_rd_o <= 1'b0;
      ram_addr_o <= 8'h00;  ram_rd_o <= 1'b0;  ram_wr_o <= 1'b0;  ram_wdata_o <= 8'h00;
    end
    else
    begin
      div_cnt_reg <= div_cnt_next;  ce_reg <= ce_next;  rst_seen_reg <= 1'b0;
      acc_reg <= acc_next;  idx_reg <= idx_next;  sp_reg <= sp_next;
      pc_reg <= pc_next;  flags_reg <= flags_next;
      op_reg <= op_next;  op1_reg <= op1_next;  op2_reg <= op2_next;
      cyc_reg <= cyc_next;  st_reg <= st_next;
      prog_addr_o <= prog_addr_next;  prog_rd_o <= prog_rd_next;
      ram_addr_o <= ram_addr_next;  ram_rd_o <= ram_rd_next;
      ram_wr_o <= ram_wr_next;  ram_wdata_o <= ram_wdata_next;
    end
  end

  assign core_ce_o = ce_reg;
  assign halted_o  = (st_reg == ST_HALT);

  // Checks
  reset_values_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    rst_seen_reg |-> acc_reg == 8'h00 && idx_reg == 8'h00 && sp_reg == 8'h00
                     && pc_reg == 16'h0000 && flags_reg == 8'h02)
    else $error("core registers not at reset values");
  push_step_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    run_ce && cyc_reg == 5'd3 && info.kind == K_PUSH_A
    |-> ram_wr_o && ram_addr_o == sp_reg ##1 sp_reg == $past(sp_reg) + 8'h01)
    else $error("push did not write at pointer then increment");
  pop_step_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    run_ce && cyc_reg == 5'd3 && info.kind inside {K_POP_A, K_POP_X}
    |-> ram_rd_o && ram_addr_o == sp_reg - 8'h01 ##1 sp_reg == $past(sp_reg) - 8'h01)
    else $error("pop did not decrement then read");
  sp_wrap_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    run_ce && cyc_reg == 5'd3 && info.kind inside {K_PUSH_A, K_PUSH_X} && sp_reg == 8'hff
    |=> sp_reg == 8'h00)
    else $error("stack pointer did not wrap to zero");
  pc_step_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    run_ce && cyc_reg == last_cyc && !is_jump
    |=> pc_reg == $past(pc_reg) + {14'h0000, $past(info.len)} && cyc_reg == 5'h00)
    else $error("program counter did not step by instruction length");
  page_cost_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    run_ce && page_pen && cyc_reg == {1'b0, info.cycles} - 5'h01
    |=> pc_reg == $past(pc_reg) && cyc_reg == $past(cyc_reg) + 5'h01)
    else $error("page crossing did not add a cycle");
  flag_or_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    run_ce && cyc_reg == 5'd3 && info.kind == K_OR_FL && op1_reg[`FLAG_BANK_BIT]
    |=> flags_reg[`FLAG_BANK_BIT] ##1 reg_bank_o)
    else $error("flag OR did not reach bank select");
  ce_spacing_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ce_reg |=> !ce_reg [*8])
    else $error("core enable faster than the top core rate");
  imm_load_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    run_ce && cyc_reg == 5'd3 && info.kind == K_MOV_A_IMM
    |=> acc_reg == $past(op1_reg) && flags_reg[`FLAG_Z_BIT] == (acc_reg == 8'h00))
    else $error("immediate load to accumulator wrong");

endmodule : core_state_addr

// ---- core_map.svh ----
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH

// Register space: flags are the only core register with an address
`define FLAGS_ADDR    8'hf7
`define FLAGS_RESET   8'h02
`define FLAG_Z_BIT    1
`define FLAG_C_BIT    2
`define FLAG_BANK_BIT 4

// Reset values of the other core registers
`define ACC_RESET 8'h00
`define IDX_RESET 8'h00
`define SP_RESET  8'h00
`define PC_RESET  16'h0000

// Core clock: fastest core rate and the least divide from the system clock
`define SYS_CLK_HZ   200000000
`define CORE_MAX_HZ  12000000
`define CORE_MIN_DIV ((`SYS_CLK_HZ + `CORE_MAX_HZ - 1) / `CORE_MAX_HZ)

// Core cycles within an instruction
`define CYC_LAST_FETCH 2
`define CYC_EXEC       3
`define CYC_LATE       4

// Opcodes
`define OP_ADD_A_IMM  8'h01
`define OP_PUSH_A     8'h08
`define OP_PUSH_X     8'h10
`define OP_POP_A      8'h18
`define OP_POP_X      8'h20
`define OP_AND_A_IMM  8'h21
`define OP_HALT       8'h30
`define OP_XOR_A_IMM  8'h31
`define OP_NOP        8'h40
`define OP_SWAP_A_X   8'h4b
`define OP_SWAP_A_SP  8'h4e
`define OP_MOV_A_IMM  8'h50
`define OP_MOV_X_IMM  8'h57
`define OP_MOV_A_X    8'h5b
`define OP_MOV_X_A    8'h5c
`define OP_RD_REG     8'h5d
`define OP_WR_REG_A   8'h60
`define OP_WR_REG_IMM 8'h62
`define OP_AND_FL     8'h70
`define OP_OR_FL      8'h71
`define OP_XOR_FL     8'h72
`define OP_INC_A      8'h74
`define OP_INC_X      8'h75
`define OP_DEC_A      8'h78
`define OP_DEC_X      8'h79
`define OP_LJMP       8'h7d
`define OP_JMP_HI     4'h8

`endif

// ---- core_pkg.sv ----
package core_pkg;

  // Operation classes after decode
  typedef enum {
    K_NOP, K_HALT, K_MOV_A_IMM, K_MOV_X_IMM, K_MOV_A_X, K_MOV_X_A, K_SWAP_A_X,
    K_SWAP_A_SP, K_AND_FL, K_OR_FL, K_XOR_FL, K_ADD_A, K_AND_A, K_XOR_A, K_INC_A,
    K_INC_X, K_DEC_A, K_DEC_X, K_PUSH_A, K_PUSH_X, K_POP_A, K_POP_X, K_RD_REG,
    K_WR_REG_A, K_WR_REG_IMM, K_JMP, K_LJMP
  } op_kind_t;

  // Decoded opcode: class, core cycles, instruction bytes
  typedef struct packed {
    op_kind_t   kind;
    logic [3:0] cycles;
    logic [1:0] len;
  } op_info_t;

  typedef enum {ST_RUN, ST_HALT} core_state_t;

endpackage : core_pkg

// ---- reg_space_port.sv ----
`timescale 1ns/100ps
`include "core_map.svh"

module reg_space_port
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  // Requests from the core
  input  wire logic       req_rd_i,
  input  wire logic       req_wr_i,
  input  wire logic [7:0] req_addr_i,
  input  wire logic [7:0] req_wdata_i,
  input  wire logic       bank_i,
  input  wire logic [7:0] flags_i,
  output logic            flags_hit_o,
  output logic [7:0]      rd_data_o,
  // Register space bus
  output logic [7:0]      reg_addr_o,
  output logic            reg_bank_o,
  output logic            reg_rd_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  logic hit_reg;
  logic hit_next;

  // Flags answer at their address in both banks; bus stays quiet then
  assign flags_hit_o = (req_addr_i == `FLAGS_ADDR);
  assign rd_data_o   = hit_reg ? flags_i : reg_rdata_i;
  // Hit held until the next request, so a flag read still answers in its late cycle
  assign hit_next    = (req_rd_i || req_wr_i) ? flags_hit_o : hit_reg;

  // Bus outputs registered so they never glitch toward peripherals
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      hit_reg     <= 1'b0;
      reg_addr_o  <= 8'h00;
      reg_bank_o  <= 1'b0;
      reg_rd_o    <= 1'b0;
      reg_wr_o    <= 1'b0;
      reg_wdata_o <= 8'h00;
    end
    else
    begin
      hit_reg     <= hit_next;
      reg_addr_o  <= req_addr_i;
      reg_bank_o  <= bank_i;
      reg_rd_o    <= req_rd_i && !flags_hit_o;
      reg_wr_o    <= req_wr_i && !flags_hit_o;
      reg_wdata_o <= req_wdata_i;
    end
  end

  // Flag address read returns the live flags
  flag_read_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    hit_reg && !reg_rd_o |-> rd_data_o == flags_i)
    else $error("flag address read did not return flags");

endmodule : reg_space_port

// ---- mem_partner.sv ----
`timescale 1ns/100ps

module mem_partner
(
  // Core timing
  input  wire logic        core_clk_i,
  input  wire logic        core_ce_i,
  // Program memory
  input  wire logic [15:0] prog_addr_i,
  input  wire logic        prog_rd_i,
  output logic [7:0]       prog_data_o,
  // Data RAM
  input  wire logic [7:0]  ram_addr_i,
  input  wire logic        ram_rd_i,
  input  wire logic        ram_wr_i,
  input  wire logic [7:0]  ram_wdata_i,
  output logic [7:0]       ram_rdata_o,
  // Register space, two banks
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_bank_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o
);
  logic [7:0] rom [0:65535];
  logic [7:0] ram [0:255];
  logic [7:0] regs [0:511];
  logic [7:0] ram_last = 8'h00;
  logic [7:0] reg_last = 8'h00;
  logic       ram_hold = 1'b0;
  logic       reg_hold = 1'b0;

  // Unused program space reads as one-byte no-ops
  initial
  begin
    foreach (rom[i]) rom[i] = 8'h40;
  end

  // Idle strobe shows inverted data, so a stale byte is never taken by luck
  assign prog_data_o = prog_rd_i ? rom[prog_addr_i] : ~rom[prog_addr_i];
  // Read data valid one core cycle past the strobe, then goes bad
  assign ram_rdata_o = ram_rd_i ? ram[ram_addr_i] : (ram_hold ? ram_last : ~ram_last);
  assign reg_rdata_o = reg_rd_i ? regs[{reg_bank_i, reg_addr_i}]
                                : (reg_hold ? reg_last : ~reg_last);

  // Memories act only on core-cycle edges
  always @(posedge core_clk_i)
  begin
    if (core_ce_i)
    begin
      if (ram_wr_i) ram[ram_addr_i] <= ram_wdata_i;
      if (reg_wr_i) regs[{reg_bank_i, reg_addr_i}] <= reg_wdata_i;
      ram_hold <= ram_rd_i;
      reg_hold <= reg_rd_i;
      if (ram_rd_i) ram_last <= ram[ram_addr_i];
      if (reg_rd_i) reg_last <= regs[{reg_bank_i, reg_addr_i}];
    end
  end
endmodule : mem_partner

// ---- cpu_core_state_and_addressing_tb_top.sv ----
`timescale 1ns/100ps

module cpu_core_state_and_addressing_tb_top;
  logic        core_clk_i, resetn_i, core_ce_o, halted_o, prog_rd_o;
  logic [1:0]  clk_sel_i;
  logic [15:0] prog_addr_o;
  logic [7:0]  prog_data_i, ram_addr_o, ram_wdata_o, ram_rdata_i;
  logic        ram_rd_o, ram_wr_o, reg_bank_o, reg_rd_o, reg_wr_o;
  logic [7:0]  reg_addr_o, reg_wdata_o, reg_rdata_i;
  logic [15:0] log_a [$];
  logic [15:0] log_c [$];
  logic [15:0] cyc;
  logic        prev_rd;
  int          num_errors = 0;
  int          checks_done = 0;

  core_state_addr u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_sel_i(clk_sel_i),
    .core_ce_o(core_ce_o), .halted_o(halted_o), .prog_addr_o(prog_addr_o),
    .prog_rd_o(prog_rd_o), .prog_data_i(prog_data_i), .ram_addr_o(ram_addr_o),
    .ram_rd_o(ram_rd_o), .ram_wr_o(ram_wr_o), .ram_wdata_o(ram_wdata_o),
    .ram_rdata_i(ram_rdata_i), .reg_addr_o(reg_addr_o), .reg_bank_o(reg_bank_o),
    .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
    .reg_rdata_i(reg_rdata_i));

  mem_partner u_mem (.core_clk_i(core_clk_i), .core_ce_i(core_ce_o),
    .prog_addr_i(prog_addr_o), .prog_rd_i(prog_rd_o), .prog_data_o(prog_data_i),
    .ram_addr_i(ram_addr_o), .ram_rd_i(ram_rd_o), .ram_wr_i(ram_wr_o),
    .ram_wdata_i(ram_wdata_o), .ram_rdata_o(ram_rdata_i), .reg_addr_i(reg_addr_o),
    .reg_bank_i(reg_bank_o), .reg_rd_i(reg_rd_o), .reg_wr_i(reg_wr_o),
    .reg_wdata_i(reg_wdata_o), .reg_rdata_o(reg_rdata_i));

  // 200 MHz system clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // Instruction starts: fetch strobe rising, stamped with the core-cycle count
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cyc = 16'h0000;
      prev_rd = 1'b0;
      log_a.delete();
      log_c.delete();
    end
    else
    begin
      if (prog_rd_o && !prev_rd) log_a.push_back(prog_addr_o);
      if (prog_rd_o && !prev_rd) log_c.push_back(cyc);
      if (core_ce_o) cyc++;
      prev_rd = prog_rd_o;
    end
  end

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // Listed core cycles and bytes of the opcodes this program uses before its final halt
  function automatic logic [15:0] op_cycles(input logic [7:0] op);
    case (op)
      8'h18, 8'h60, 8'h4e: return 16'h0005;
      8'h5d: return 16'h0006;
      8'h62: return 16'h0008;
      8'h7d: return 16'h0007;
      default: return 16'h0004;
    endcase
  endfunction : op_cycles

  function automatic logic [15:0] op_len(input logic [7:0] op);
    case (op)
      8'h50, 8'h57, 8'h60, 8'h5d, 8'h70, 8'h71, 8'h72: return 16'h0002;
      8'h62, 8'h7d: return 16'h0003;
      default: return 16'h0001;
    endcase
  endfunction : op_len

  // Bank 1 is entered only for a flag read and two register writes and left again
  task automatic load(input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] r3);
    logic [7:0] p [$];
    p = '{8'h5d, 8'hf7, 8'h60, 8'h40, 8'h50, r1, 8'h08, 8'h57, r2, 8'h10, 8'h18,
          8'h60, 8'h10, 8'h70, 8'h00, 8'h71, 8'h10, 8'h5d, 8'hf7, 8'h60, 8'h20,
          8'h62, 8'h21, r3, 8'h72, 8'h10, 8'h50, 8'hff, 8'h4e, 8'h08, 8'h10,
          8'h7d, 8'h01, 8'hfd, 8'h60, 8'h30, 8'h40, 8'h30};
    // Tail lands at the long jump target 01fdh, so its no-op crosses a page
    foreach (p[i]) u_mem.rom[(i < 34) ? 16'(i) : 16'(i) + 16'h01db] = p[i];
  endtask : load

  initial
  begin
    logic [7:0]  r1, r2, r3, op;
    logic [15:0] a;
    int          n;
    n = $urandom(27364);
    resetn_i = 1'b0;
    clk_sel_i = 2'b00;
    for (int run = 0; run < 3; run++)
    begin
      r1 = 8'($urandom_range(1, 255));
      r2 = 8'($urandom_range(1, 255));
      r3 = 8'($urandom_range(0, 255));
      load(r1, r2, r3);
      clk_sel_i = 2'($urandom_range(0, 2));
      repeat (8) @(posedge core_clk_i);
      cmp_byte({7'h00, prog_rd_o}, 8'h00);
      #1 resetn_i = 1'b1;
      // First run is cut short by a second reset in mid-program
      if (run == 0) repeat (700) @(posedge core_clk_i);
      if (run == 0) #1 resetn_i = 1'b0;
      if (run == 0) repeat (2) @(posedge core_clk_i);
      if (run == 0) #1 resetn_i = 1'b1;
      n = 0;
      while (halted_o !== 1'b1 && n < 20000)
      begin
        @(posedge core_clk_i);
        n++;
      end
      cmp_byte({7'h00, halted_o}, 8'h01);
      cmp_word(log_a[$], 16'h0200);
      for (int i = 0; i + 1 < log_a.size(); i++)
      begin
        a = log_a[i];
        op = u_mem.rom[a];
        cmp_word(log_a[i + 1], (op == 8'h7d) ? {u_mem.rom[a + 1], u_mem.rom[a + 2]}
                                             : a + op_len(op));
        cmp_word(log_c[i + 1] - log_c[i], op_cycles(op)
                 + 16'((op != 8'h7d) && ({8'h00, a[7:0]} + op_len(op) > 16'h00ff)));
      end
      cmp_byte(u_mem.regs[9'h040], 8'h02);
      cmp_byte(u_mem.regs[9'h010], r2);
      cmp_byte(u_mem.regs[9'h120], 8'h10);
      cmp_byte(u_mem.regs[9'h121], r3);
      cmp_byte(u_mem.regs[9'h030], 8'h01);
      cmp_byte(u_mem.ram[1], r2);
      cmp_byte(u_mem.ram[255], 8'h01);
      cmp_byte(u_mem.ram[0], r2);
      @(posedge core_clk_i);
      #1 resetn_i = 1'b0;
    end
    conclude();
  end

  // Three runs need well under 80k clocks
  initial
  begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule : cpu_core_state_and_addressing_tb_top
